// *** hdl/otp_pkg.sv ***
// constants for the one-time-programmable eprom program and verify block
// assumes a 20 MHz system clock and pins already at logic levels
package otp_pkg;
    localparam int          CLK_PERIOD_NS      = 50;
    localparam int          OSC_MAX_FREQ_KHZ   = 6000;
    localparam int          VERIFY_OSC_PERIODS = 48;
    localparam int          VERIFY_LIMIT_NS    = (VERIFY_OSC_PERIODS * 1000000) / OSC_MAX_FREQ_KHZ;
    localparam int          VERIFY_LIMIT_CYC   = VERIFY_LIMIT_NS / CLK_PERIOD_NS;
    localparam int          ADDR_W             = 13;
    localparam int          ENC_W              = 5;
    localparam logic [4:0]  PULSES_PER_BYTE    = 5'h19;
    localparam logic [12:0] SIG_ADDR_MAKER     = 13'h0030;
    localparam logic [12:0] SIG_ADDR_PART      = 13'h0031;
    localparam logic [7:0]  ERASED_BYTE        = 8'hFF;
    localparam logic [7:0]  SIG_UNUSED_BYTE    = 8'hFF;
    localparam logic [3:0]  CTRL_OFFSET        = 4'h0;
    localparam logic [3:0]  STAT_OFFSET        = 4'h4;
    localparam int          CTRL_ERASE_BIT     = 0;
    localparam int          STAT_SEC1_BIT      = 0;
    localparam int          STAT_SEC2_BIT      = 1;
    localparam int          STAT_ENC_BIT       = 2;
    localparam int          STAT_BUSY_BIT      = 3;
    localparam int          STAT_READ_BIT      = 4;
    localparam int          STAT_CNT_LSB       = 8;
    localparam logic        ERASE_BUSY_RESET   = 1'b1;
endpackage

// *** hdl/otp_program_verify.sv ***
// pin-driven program / verify engine for an on-chip code eprom, with a small avalon-mm status port
// assumes all pin inputs are asynchronous to clock; port0 pull-ups and tristate are outside
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - with encryption programmed, verify returns code byte xnor table byte.
// - no mode ever reads the encryption table out.
// - once any security bit is set, code and table writes are ignored.
// - code verify readout only while security bit two is clear.
// - in verify the device drives the addressed byte onto port 0.
// - signature bytes read at 030h and 031h with port 3 bits 7,6 low.
// - two fixed signature bytes: maker and part.
// - verify data valid within 48 periods; port 0 floats when enable rises.
// - erased array reads all ones.
module otp_program_verify
    import otp_pkg::*;
#(
    parameter logic [7:0] SIG_MAKER = 8'hA5,  // arbitrary value
    parameter logic [7:0] SIG_PART  = 8'h3C   // arbitrary value
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        reset_pin,
    input  wire logic        store_fetch_strobe_n,
    input  wire logic        program_strobe_n,
    input  wire logic        ext_access_prog_supply,
    input  wire logic        prog_supply_present,
    input  wire logic        port2_bit7_enable,
    input  wire logic        port2_bit6_sel,
    input  wire logic        port3_bit7_sel,
    input  wire logic        port3_bit6_sel,
    input  wire logic [7:0]  port1_addr,
    input  wire logic [4:0]  port2_addr,
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic             port0_oe,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    localparam int NPIN = 30;
    localparam int VERIFY_MAX = VERIFY_LIMIT_CYC;
    // strobe bit resets to its idle high level, so no false strobe edge follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = 30'h0000_0040;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: every pin passes two flops before use
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic            strobe_prev;
    wire  [NPIN-1:0] pin_raw = {port0_in, port2_addr, port1_addr, reset_pin, store_fetch_strobe_n,
                                program_strobe_n, ext_access_prog_supply, prog_supply_present,
                                port2_bit7_enable, port2_bit6_sel, port3_bit7_sel, port3_bit6_sel};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta    <= PIN_IDLE;
            pin_sync    <= PIN_IDLE;
            strobe_prev <= 1'b1;
        end else begin
            pin_meta    <= pin_raw;
            pin_sync    <= pin_meta;
            strobe_prev <= pin_sync[6];
        end
    end

    wire [7:0]        data_in  = pin_sync[29:22];
    wire [ADDR_W-1:0] addr     = pin_sync[21:9];
    wire              rst_pin  = pin_sync[8];
    wire              store_n  = pin_sync[7];
    wire              strobe_n = pin_sync[6];
    wire              acc_high = pin_sync[5];
    wire              supply   = pin_sync[4];
    wire              en27     = pin_sync[3];
    wire              sel26    = pin_sync[2];
    wire              sel37    = pin_sync[1];
    wire              sel36    = pin_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    wire base_mode = rst_pin & ~store_n;
    wire read_mode = base_mode & strobe_n & acc_high & ~en27 & ~sel26;
    wire sig_mode  = read_mode & ~sel37 & ~sel36;
    wire ver_mode  = read_mode & sel37 & sel36;
    wire prog_mode = base_mode & supply & en27;
    wire pgm_code  = prog_mode & ~sel26 & sel37 & sel36;
    wire pgm_enc   = prog_mode & ~sel26 & sel37 & ~sel36;
    wire pgm_sec1  = prog_mode & sel26 & sel37 & sel36;
    wire pgm_sec2  = prog_mode & sel26 & ~sel37 & ~sel36;
    wire strobe_fall = strobe_prev & ~strobe_n;
    wire strobe_rise = ~strobe_prev & strobe_n;

    ////////////////////////////////////////////////////////////////////////////
    // pulse counting and commit
    logic [4:0]        pulse_cnt;
    logic              sec1;
    logic              sec2;
    logic              enc_done;
    logic              erase_busy;
    logic [ADDR_W-1:0] erase_addr;

    wire secured    = sec1 | sec2;
    // the commit waits for the 25th rising edge so a short count never half-writes a cell
    wire commit     = prog_mode & strobe_rise & (pulse_cnt == PULSES_PER_BYTE) & ~erase_busy;
    wire code_wr    = commit & pgm_code & ~secured;
    wire enc_wr     = commit & pgm_enc & ~secured;
    wire erase_req  = avs_write & ~avs_waitrequest & (avs_address == CTRL_OFFSET)
                      & avs_writedata[CTRL_ERASE_BIT];
    wire erase_last = erase_busy & (erase_addr == {ADDR_W{1'b1}});

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= '0;
        end else if (!prog_mode || commit) begin
            pulse_cnt <= '0;
        end else if (strobe_fall && pulse_cnt != PULSES_PER_BYTE) begin
            pulse_cnt <= pulse_cnt + 5'h01;
        end
    end

    // security bits are accepted even when the other one is already set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sec1       <= 1'b0;
            sec2       <= 1'b0;
            enc_done   <= 1'b0;
            erase_busy <= ERASE_BUSY_RESET;
            erase_addr <= '0;
        end else if (erase_busy) begin
            sec1       <= 1'b0;
            sec2       <= 1'b0;
            enc_done   <= 1'b0;
            erase_busy <= ~erase_last;
            erase_addr <= erase_addr + 13'h0001;
        end else begin
            sec1       <= sec1 | (commit & pgm_sec1);
            sec2       <= sec2 | (commit & pgm_sec2);
            enc_done   <= enc_done | enc_wr;
            erase_busy <= erase_req;
            erase_addr <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arrays: programming can only clear bits, as in a real cell
    logic [7:0] code_mem [2**ADDR_W];
    logic [7:0] enc_mem  [2**ENC_W];

    always_ff @(posedge clock) begin
        if (erase_busy) begin
            code_mem[erase_addr] <= ERASED_BYTE;
            enc_mem[erase_addr[ENC_W-1:0]] <= ERASED_BYTE;
        end else begin
            if (code_wr) begin
                code_mem[addr] <= code_mem[addr] & data_in;
            end
            if (enc_wr) begin
                enc_mem[addr[ENC_W-1:0]] <= enc_mem[addr[ENC_W-1:0]] & data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readout; the table only ever feeds the xnor, never port 0 directly
    wire [7:0] code_byte = code_mem[addr];
    wire [7:0] enc_byte  = enc_mem[addr[ENC_W-1:0]];
    wire [7:0] ver_byte  = enc_done ? ~(code_byte ^ enc_byte) : code_byte;
    wire [7:0] sig_byte  = (addr == SIG_ADDR_MAKER) ? SIG_MAKER :
                           (addr == SIG_ADDR_PART)  ? SIG_PART : SIG_UNUSED_BYTE;
    wire       ver_ok    = ver_mode & ~sec2 & ~erase_busy;
    wire       next_oe   = sig_mode | ver_ok;
    wire [7:0] next_out  = sig_mode ? sig_byte : (ver_ok ? ver_byte : 8'h00);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port0_oe  <= 1'b0;
            port0_out <= 8'h00;
        end else begin
            port0_oe  <= next_oe;
            port0_out <= next_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait state, answer at the second edge of a request
    wire        bus_req   = avs_read | avs_write;
    wire [31:0] stat_word = {19'h0_0000, pulse_cnt, 3'h0, port0_oe, erase_busy, enc_done, sec2, sec1};
    wire [31:0] ctrl_word = {31'h0000_0000, erase_busy};
    wire [31:0] next_rd   = (avs_address == STAT_OFFSET) ? stat_word :
                            (avs_address == CTRL_OFFSET) ? ctrl_word : 32'h0000_0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            avs_readdata    <= (avs_read & avs_waitrequest) ? next_rd : avs_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_commit_count;
        @(posedge clock) disable iff (!rst_n) commit |-> $past(pulse_cnt) == PULSES_PER_BYTE;
    endproperty
    a_commit_count: assert property (p_commit_count) else $error("byte written without 25 pulses");

    property p_xnor;
        @(posedge clock) disable iff (!rst_n)
        (ver_ok && !sig_mode && enc_done) |=> port0_out == ~($past(code_byte) ^ $past(enc_byte));
    endproperty
    a_xnor: assert property (p_xnor) else $error("verify data not scrambled");

    property p_locked;
        @(posedge clock) disable iff (!rst_n) secured |-> !code_wr && !enc_wr;
    endproperty
    a_locked: assert property (p_locked) else $error("write while secured");

    // watches the cell itself, so it still trips if the lock term is lost from the write enable
    property p_locked_mem;
        @(posedge clock) disable iff (!rst_n) (secured && !erase_busy) ##1 $stable(addr) |-> $stable(code_byte);
    endproperty
    a_locked_mem: assert property (p_locked_mem) else $error("code cell changed while secured");

    property p_sec2_hides;
        @(posedge clock) disable iff (!rst_n)
        (sec2 && !sig_mode && !pgm_sec2) |=> !port0_oe;
    endproperty
    a_sec2_hides: assert property (p_sec2_hides) else $error("code read with security bit two set");

    property p_sig_maker;
        @(posedge clock) disable iff (!rst_n)
        (sig_mode && addr == SIG_ADDR_MAKER) |=> port0_oe && port0_out == SIG_MAKER;
    endproperty
    a_sig_maker: assert property (p_sig_maker) else $error("maker signature wrong");

    property p_sig_part;
        @(posedge clock) disable iff (!rst_n) (sig_mode && addr == SIG_ADDR_PART) |=> port0_out == SIG_PART;
    endproperty
    a_sig_part: assert property (p_sig_part) else $error("part signature wrong");

    property p_float;
        @(posedge clock) disable iff (!rst_n) $rose(port2_bit7_enable) |-> ##[1:VERIFY_MAX] !port0_oe;
    endproperty
    a_float: assert property (p_float) else $error("port 0 not floated");

    property p_erased;
        @(posedge clock) disable iff (!rst_n) $fell(erase_busy) |-> !sec1 && !sec2 && !enc_done;
    endproperty
    a_erased: assert property (p_erased) else $error("erase left state behind");

    property p_bus_answer;
        @(posedge clock) disable iff (!rst_n) (bus_req && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_code_write: cover property (@(posedge clock) disable iff (!rst_n) code_wr);
    c_enc_write:  cover property (@(posedge clock) disable iff (!rst_n) enc_wr);
    c_sig_read:   cover property (@(posedge clock) disable iff (!rst_n) sig_mode ##1 port0_oe);
    c_locked:     cover property (@(posedge clock) disable iff (!rst_n) secured && commit && pgm_code);
endmodule

// *** testbench/otp_programmer_model.sv ***
// programmer model: drives mode levels, address, data and the program strobe of the eprom block
// assumes the bench gives the clock and feeds back port 0 with its pull-ups applied
module otp_programmer_model #(
    parameter int LOW_CYC   = 2000,
    parameter int HIGH_CYC  = 200,
    parameter int SETUP_CYC = 240
) (
    input  wire logic       clock,
    input  wire logic [7:0] port0_level,
    output logic            reset_pin,
    output logic            store_fetch_strobe_n,
    output logic            program_strobe_n,
    output logic            ext_access_prog_supply,
    output logic            prog_supply_present,
    output logic            port2_bit7_enable,
    output logic            port2_bit6_sel,
    output logic            port3_bit7_sel,
    output logic            port3_bit6_sel,
    output logic      [7:0] port1_addr,
    output logic      [4:0] port2_addr,
    output logic      [7:0] port0_in
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////////////
    // idle levels are verify mode, so the block may drive port 0 between transfers
    initial begin
        {reset_pin, store_fetch_strobe_n, program_strobe_n, ext_access_prog_supply} = 4'b1011;
        {prog_supply_present, port2_bit7_enable} = 2'b00;
        {port2_bit6_sel, port3_bit7_sel, port3_bit6_sel} = 3'b011;
        {port2_addr, port1_addr, port0_in} = 21'h00_0000;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // entry levels {reset pin, store strobe, external access}; 3'h5 is the legal read entry
    task automatic entry(input logic [2:0] lv);
        @(posedge clock);
        {reset_pin, store_fetch_strobe_n, ext_access_prog_supply} <= lv;
    endtask
    // enable before supply, supply around the strobe train, teardown in reverse
    task automatic program_byte(input logic [2:0] sel, input logic [12:0] ad, input logic [7:0] d, input int pulses);
        @(posedge clock);
        {port2_addr, port1_addr, port0_in} <= {ad, d};
        {port2_bit7_enable, port2_bit6_sel, port3_bit7_sel, port3_bit6_sel} <= {1'b1, sel};
        hold(SETUP_CYC);
        prog_supply_present <= 1'b1;
        hold(SETUP_CYC);
        repeat (pulses) begin
            program_strobe_n <= 1'b0;
            hold(LOW_CYC);
            program_strobe_n <= 1'b1;
            hold(HIGH_CYC);
        end
        hold(SETUP_CYC);
        prog_supply_present <= 1'b0;
        hold(SETUP_CYC);
        {port2_bit7_enable, port2_bit6_sel, port3_bit7_sel, port3_bit6_sel} <= 4'b0011;
        port0_in <= ~d; // released data lines do not keep the old byte
    endtask
    task automatic read_byte(input logic sig, input logic [12:0] ad, output logic [7:0] q);
        @(posedge clock);
        {port2_addr, port1_addr} <= ad;
        {port3_bit7_sel, port3_bit6_sel} <= sig ? 2'b00 : 2'b11;
        hold(4);
        q = port0_level;
    endtask
endmodule

// *** testbench/test_otp_program_verify.sv ***
// self-checking bench: eprom block against a behavioural array, table and lock model
// assumes the programmer model drives all pins and port 0 has pull-ups
module test_otp_program_verify
    import otp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] SEL_CODE = 3'b011, SEL_ENC = 3'b010, SEL_SEC1 = 3'b111, SEL_SEC2 = 3'b100;
    localparam logic [7:0] SIG_M = 8'h5A, SIG_P = 8'hC3; // arbitrary values
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        reset_pin, store_fetch_strobe_n, program_strobe_n, ext_access_prog_supply, prog_supply_present;
    logic        port2_bit7_enable, port2_bit6_sel, port3_bit7_sel, port3_bit6_sel, port0_oe, avs_waitrequest;
    logic [7:0]  port1_addr, port0_in, port0_out, got;
    logic [4:0]  port2_addr;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    logic [7:0]  mem [0:8191];
    logic [7:0]  enc [0:31];
    logic        sec1, sec2, encp;
    logic [12:0] a;
    int          n_fail = 0, checks = 0;
    integer      seed = 32'h0000_011a;
    wire  [7:0]  port0_level = port0_oe ? port0_out : 8'hFF; // pull-ups when released
    always #25 clock = ~clock; // never paused
    otp_program_verify #(.SIG_MAKER(SIG_M), .SIG_PART(SIG_P)) u_otp_program_verify (.clock, .rst_n, .reset_pin,
        .store_fetch_strobe_n, .program_strobe_n, .ext_access_prog_supply, .prog_supply_present, .port2_bit7_enable,
        .port2_bit6_sel, .port3_bit7_sel, .port3_bit6_sel, .port1_addr, .port2_addr, .port0_in, .port0_out,
        .port0_oe, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    otp_programmer_model #(.LOW_CYC(4), .HIGH_CYC(4), .SETUP_CYC(4)) u_otp_programmer_model (.clock, .port0_level,
        .reset_pin, .store_fetch_strobe_n, .program_strobe_n, .ext_access_prog_supply, .prog_supply_present,
        .port2_bit7_enable, .port2_bit6_sel, .port3_bit7_sel, .port3_bit6_sel, .port1_addr, .port2_addr, .port0_in);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic hang_out;
        n_fail++;
        give_verdict;
    endtask
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        {avs_address, avs_writedata, avs_write, avs_read} <= {ad, wd, wr, !wr};
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        if (avs_waitrequest !== 1'b0) hang_out;
    endtask
    // the model erases at once; the block is polled until its sweep ends
    task automatic erase_wait;
        for (int i = 0; i < 8192; i++) mem[i] = ERASED_BYTE;
        for (int i = 0; i < 32; i++) enc[i] = ERASED_BYTE;
        {sec1, sec2, encp} = 3'b000;
        rd = 32'h0000_0001;
        for (int i = 0; i < 6000 && rd[CTRL_ERASE_BIT] !== 1'b0; i++) bus(1'b0, CTRL_OFFSET, 32'h0000_0000, rd);
        if (rd[CTRL_ERASE_BIT] !== 1'b0) hang_out;
    endtask
    task automatic prog(input logic [2:0] sel, input logic [12:0] ad, input logic [7:0] d, input int pulses);
        u_otp_programmer_model.program_byte(sel, ad, d, pulses);
        if (pulses == 25 && !(sec1 || sec2) && sel == SEL_CODE) mem[ad] &= d;
        if (pulses == 25 && !(sec1 || sec2) && sel == SEL_ENC) begin
            enc[ad[4:0]] &= d;
            encp = 1'b1;
        end
        if (pulses == 25 && sel == SEL_SEC1) sec1 = 1'b1;
        if (pulses == 25 && sel == SEL_SEC2) sec2 = 1'b1;
    endtask
    task automatic verify(input logic [12:0] ad);
        u_otp_programmer_model.read_byte(1'b0, ad, got);
        compare("verify byte", sec2 ? 32'h0000_00FF : {24'h00_0000, (encp ? ~(mem[ad] ^ enc[ad[4:0]]) : mem[ad])},
                {24'h00_0000, got});
    endtask
    task automatic sig_read(input logic [12:0] ad, input logic [7:0] exp);
        u_otp_programmer_model.read_byte(1'b1, ad, got);
        compare("signature byte", {24'h00_0000, exp}, {24'h00_0000, got});
    endtask
    task automatic status_check;
        bus(1'b0, STAT_OFFSET, 32'h0000_0000, rd);
        compare("status flags", 32'(sec1) << STAT_SEC1_BIT | 32'(sec2) << STAT_SEC2_BIT | 32'(encp) << STAT_ENC_BIT,
                rd & 32'h0000_000F);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        erase_wait;
        bus(1'b0, 4'h8, 32'h0000_0000, rd);
        compare("unmapped read", 32'h0000_0000, rd);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
        status_check;
        for (int i = 0; i < 3; i++) verify(13'($random(seed)));
        a = 13'($random(seed));
        prog(SEL_CODE, a, 8'($random(seed)), 25);
        verify(a);
        prog(SEL_CODE, a, 8'($random(seed)), 25);
        verify(a);
        prog(SEL_CODE, a + 13'h0001, 8'h00, 24);
        verify(a + 13'h0001);
        sig_read(SIG_ADDR_MAKER, SIG_M);
        sig_read(SIG_ADDR_PART, SIG_P);
        sig_read(13'h0032, SIG_UNUSED_BYTE);
        for (int k = 0; k < 3; k++) begin
            u_otp_programmer_model.entry(k == 0 ? 3'h1 : (k == 1 ? 3'h7 : 3'h4));
            sig_read(SIG_ADDR_MAKER, 8'hFF);
        end
        u_otp_programmer_model.entry(3'h5);
        for (int t = 0; t < 32; t++) prog(SEL_ENC, 13'(t), 8'($random(seed)), 25);
        status_check;
        verify(a);
        verify(13'($random(seed)));
        sig_read(13'h0000, SIG_UNUSED_BYTE);
        prog(SEL_SEC1, a, 8'h00, 25);
        prog(SEL_CODE, a, 8'h00, 25);
        prog(SEL_ENC, a, 8'h00, 25);
        verify(a);
        prog(SEL_SEC2, a, 8'h00, 25);
        status_check;
        verify(a);
        sig_read(SIG_ADDR_MAKER, SIG_M);
        bus(1'b1, CTRL_OFFSET, 32'h0000_0001 << CTRL_ERASE_BIT, rd);
        erase_wait;
        verify(a);
        status_check;
        give_verdict;
    end
    initial begin
        repeat (60000) @(posedge clock);
        hang_out;
    end
endmodule
